//--- shared/periph_irq_cfg.svh
// Offsets, field positions, masks and reset values for the peripheral
// interrupt enable/priority block. Definitions only.
`ifndef PERIPH_IRQ_CFG_SVH
`define PERIPH_IRQ_CFG_SVH

`define IRQ_ADDR_W        4
`define IRQ_DATA_W        8

`define OFS_ENABLE3       4'h0
`define OFS_PRIORITY1     4'h1
`define OFS_PRIORITY2     4'h2
`define OFS_PRIORITY3     4'h3
`define OFS_CONTROL       4'h4
`define OFS_STATUS        4'h5
`define OFS_MASK          4'h6

`define ENABLE3_MASK      8'h76
`define ENABLE3_RESET     8'h00
`define PRIORITY1_MASK    8'h7B
`define PRIORITY1_RESET   8'h7B
`define PRIORITY2_MASK    8'hFF
`define PRIORITY2_RESET   8'hFF
`define PRIORITY3_MASK    8'h76
`define PRIORITY3_RESET   8'h76
`define CONTROL_MASK      8'h01
`define CONTROL_RESET     8'h00
`define STATUS_MASK       8'h03
`define STATUS_RESET      8'h00
`define MASK_RESET        8'h00
`define ZERO_BYTE         8'h00

`define BIT_GPE           0
`define BIT_EV_HIGH       0
`define BIT_EV_LOW        1
`define BIT_DISPLAY       6
`define BIT_SERIAL2_RX    5
`define BIT_SERIAL2_TX    4
`define BIT_CAPCOMP2      2
`define BIT_CAPCOMP1      1
`define BIT_ADC           6
`define BIT_SERIAL1_RX    5
`define BIT_SERIAL1_TX    4
`define BIT_SYNC_SERIAL   3
`define BIT_TIMER2        1
`define BIT_TIMER1        0

`endif

//--- shared/periph_irq_pkg.sv
// Types shared by the peripheral interrupt enable/priority block.
// Assumes periph_irq_cfg.svh is on the include path.
`include "periph_irq_cfg.svh"

package periph_irq_pkg;

  typedef logic [`IRQ_DATA_W-1:0] byte_t;

  typedef struct packed {
    logic [`IRQ_ADDR_W-1:0] addr;
    byte_t                  wdata;
    logic                   wr;
    logic                   rd;
  } reg_req_t;

  typedef struct packed {
    logic high;
    logic low;
  } irq_req_t;

endpackage

//--- design/irq_route.sv
// One group of eight peripheral sources: gates flags by enables and
// steers each request to the high or low level.
// Assumes inputs synchronous to the clock.
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"

module irq_route
  import periph_irq_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_reset_n,
  input  wire byte_t    i_flags,
  input  wire byte_t    i_enable,
  input  wire byte_t    i_priority,
  input  wire logic     i_gpe,
  output irq_req_t      o_req
);

  byte_t    active;
  irq_req_t next_req;

  always_comb begin
    active = i_flags & i_enable;
    if (i_gpe) begin
      next_req.high = |(active & i_priority);
      next_req.low  = |(active & ~i_priority);
    end else begin
      // Legacy mode: priority bits ignored, everything goes high
      next_req.high = |active;
      next_req.low  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_req <= '0;
    end else begin
      o_req <= next_req;
    end
  end

endmodule

//--- design/periph_irq_ctrl.sv
// Peripheral interrupt enable register 3, priority registers 1..3,
// global priority enable and a small event status/mask pair.
// Assumes a single-clock register port with reads answered next cycle.
//
// Contract
// - Enable bit 1 gates capture/compare 1
// - Unimplemented bits read zero, ignore writes
// - Three separate peripheral priority registers exist
// - Priority bits matter only with global enable
// - Priority1 bit 6 sets converter priority
// - Priority1 bit 5 sets serial1 receive priority
// - Priority1 bit 4 sets serial1 transmit priority
// - Priority1 bits 3,1,0 implemented, reset one
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"

module periph_irq_ctrl
  import periph_irq_pkg::*;
(
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RESET_N,
  input  wire logic [`IRQ_ADDR_W-1:0] I_ADDR,
  input  wire byte_t                  I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  input  wire byte_t                  I_GROUP1_FLAGS,
  input  wire byte_t                  I_GROUP1_ENABLE,
  input  wire byte_t                  I_GROUP3_FLAGS,
  input  wire logic                   I_DISPLAY_TYPE_B,
  input  wire logic                   I_DISPLAY_NONSTATIC,
  output byte_t                       O_RDATA,
  output logic                        O_IRQ_HIGH,
  output logic                        O_IRQ_LOW,
  output logic                        O_IRQ
);

  function automatic byte_t masked(input byte_t value, input byte_t keep);
    masked = value & keep;
  endfunction

  function automatic logic hit(input reg_req_t req,
                               input logic [`IRQ_ADDR_W-1:0] ofs);
    hit = req.wr && (req.addr == ofs);
  endfunction

  reg_req_t req;
  byte_t    peripheral_irq_enable_3;
  byte_t    peripheral_irq_priority_1;
  byte_t    peripheral_irq_priority_2;
  byte_t    peripheral_irq_priority_3;
  byte_t    control;
  byte_t    status;
  byte_t    mask;
  byte_t    enable3_eff;
  byte_t    status_set;
  byte_t    status_clr;
  byte_t    next_rdata;
  logic     global_priority_enable;
  logic     display_mode_ok;
  logic     high_q;
  logic     low_q;
  irq_req_t req1;
  irq_req_t req3;

  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign global_priority_enable = control[`BIT_GPE];
  assign display_mode_ok = I_DISPLAY_TYPE_B && I_DISPLAY_NONSTATIC;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      peripheral_irq_enable_3 <= `ENABLE3_RESET;
    end else if (hit(req, `OFS_ENABLE3)) begin
      peripheral_irq_enable_3 <= masked(req.wdata, `ENABLE3_MASK);
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      peripheral_irq_priority_1 <= `PRIORITY1_RESET;
      peripheral_irq_priority_2 <= `PRIORITY2_RESET;
      peripheral_irq_priority_3 <= `PRIORITY3_RESET;
    end else begin
      if (hit(req, `OFS_PRIORITY1)) begin
        peripheral_irq_priority_1 <= masked(req.wdata, `PRIORITY1_MASK);
      end
      if (hit(req, `OFS_PRIORITY2)) begin
        peripheral_irq_priority_2 <= masked(req.wdata, `PRIORITY2_MASK);
      end
      if (hit(req, `OFS_PRIORITY3)) begin
        peripheral_irq_priority_3 <= masked(req.wdata, `PRIORITY3_MASK);
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      control <= `CONTROL_RESET;
      mask    <= `MASK_RESET;
    end else begin
      if (hit(req, `OFS_CONTROL)) begin
        control <= masked(req.wdata, `CONTROL_MASK);
      end
      if (hit(req, `OFS_MASK)) begin
        mask <= masked(req.wdata, `STATUS_MASK);
      end
    end
  end

  // Display enable is forced off outside the mode where it is valid
  always_comb begin
    enable3_eff = peripheral_irq_enable_3;
    enable3_eff[`BIT_DISPLAY] = peripheral_irq_enable_3[`BIT_DISPLAY]
                                && display_mode_ok;
  end

  irq_route u_group1 (
    .i_clk      (I_SYS_CLK),
    .i_reset_n  (I_RESET_N),
    .i_flags    (I_GROUP1_FLAGS),
    .i_enable   (I_GROUP1_ENABLE),
    .i_priority (peripheral_irq_priority_1),
    .i_gpe      (global_priority_enable),
    .o_req      (req1)
  );

  irq_route u_group3 (
    .i_clk      (I_SYS_CLK),
    .i_reset_n  (I_RESET_N),
    .i_flags    (I_GROUP3_FLAGS),
    .i_enable   (enable3_eff),
    .i_priority (peripheral_irq_priority_3),
    .i_gpe      (global_priority_enable),
    .o_req      (req3)
  );

  assign O_IRQ_HIGH = req1.high || req3.high;
  assign O_IRQ_LOW  = req1.low  || req3.low;

  // Events are the rising edges of the two request levels
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      high_q <= 1'b0;
      low_q  <= 1'b0;
    end else begin
      high_q <= O_IRQ_HIGH;
      low_q  <= O_IRQ_LOW;
    end
  end

  always_comb begin
    status_set = `ZERO_BYTE;
    status_set[`BIT_EV_HIGH] = O_IRQ_HIGH && !high_q;
    status_set[`BIT_EV_LOW]  = O_IRQ_LOW  && !low_q;
    status_clr = hit(req, `OFS_STATUS) ? req.wdata : `ZERO_BYTE;
  end

  // Set beats a same-cycle write-one-to-clear so no event is lost
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      status <= `STATUS_RESET;
    end else begin
      status <= masked((status & ~status_clr) | status_set, `STATUS_MASK);
    end
  end

  assign O_IRQ = |(status & mask);

  always_comb begin
    case (req.addr)
      `OFS_ENABLE3:   next_rdata = peripheral_irq_enable_3;
      `OFS_PRIORITY1: next_rdata = peripheral_irq_priority_1;
      `OFS_PRIORITY2: next_rdata = peripheral_irq_priority_2;
      `OFS_PRIORITY3: next_rdata = peripheral_irq_priority_3;
      `OFS_CONTROL:   next_rdata = control;
      `OFS_STATUS:    next_rdata = status;
      `OFS_MASK:      next_rdata = mask;
      default:        next_rdata = `ZERO_BYTE;
    endcase
  end

  // Read data held only in the cycle after the strobe
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= `ZERO_BYTE;
    end else if (req.rd) begin
      O_RDATA <= next_rdata;
    end else begin
      O_RDATA <= `ZERO_BYTE;
    end
  end

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  chk_unimpl_read_zero: assert property (
    (req.rd && req.addr == `OFS_ENABLE3)
      |=> ((O_RDATA & ~`ENABLE3_MASK) == `ZERO_BYTE))
    else $error("enable3 unimplemented bits read nonzero");

  chk_enable3_write: assert property (
    hit(req, `OFS_ENABLE3)
      |=> peripheral_irq_enable_3 == ($past(I_WDATA) & `ENABLE3_MASK))
    else $error("enable3 write not stored");

  chk_prio1_write: assert property (
    hit(req, `OFS_PRIORITY1)
      |=> peripheral_irq_priority_1 == ($past(I_WDATA) & `PRIORITY1_MASK))
    else $error("priority1 write not stored");

  chk_prio2_readback: assert property (
    (req.rd && req.addr == `OFS_PRIORITY2)
      |=> O_RDATA == $past(peripheral_irq_priority_2))
    else $error("priority2 readback wrong");

  chk_gpe_off_no_low: assert property (
    !global_priority_enable |=> !O_IRQ_LOW)
    else $error("low request while global priority off");

  chk_capcomp1_gate: assert property (
    (I_GROUP3_FLAGS == 8'h02 && !peripheral_irq_enable_3[`BIT_CAPCOMP1])
      |=> !(req3.high || req3.low))
    else $error("capcomp1 passed while disabled");

  chk_capcomp1_low: assert property (
    (I_GROUP3_FLAGS == 8'h02 && peripheral_irq_enable_3[`BIT_CAPCOMP1]
     && global_priority_enable
     && !peripheral_irq_priority_3[`BIT_CAPCOMP1])
      |=> req3.low && !req3.high)
    else $error("capcomp1 not routed low");

  chk_display_mode: assert property (
    (I_GROUP3_FLAGS == 8'h40 && !display_mode_ok) |=> !(req3.high || req3.low))
    else $error("display request outside valid mode");

  chk_adc_high: assert property (
    (global_priority_enable && I_GROUP1_FLAGS == 8'h40
     && I_GROUP1_ENABLE[`BIT_ADC] && peripheral_irq_priority_1[`BIT_ADC])
      |=> req1.high && !req1.low)
    else $error("converter not routed high");

  chk_serial1_rx_low: assert property (
    (global_priority_enable && I_GROUP1_FLAGS == 8'h20
     && I_GROUP1_ENABLE[`BIT_SERIAL1_RX]
     && !peripheral_irq_priority_1[`BIT_SERIAL1_RX])
      |=> req1.low && !req1.high)
    else $error("serial1 receive not routed low");

  chk_serial1_tx_low: assert property (
    (global_priority_enable && I_GROUP1_FLAGS == 8'h10
     && I_GROUP1_ENABLE[`BIT_SERIAL1_TX]
     && !peripheral_irq_priority_1[`BIT_SERIAL1_TX])
      |=> req1.low && !req1.high)
    else $error("serial1 transmit not routed low");

  chk_status_set_wins: assert property (
    (status_set[`BIT_EV_HIGH] && status_clr[`BIT_EV_HIGH])
      |=> status[`BIT_EV_HIGH])
    else $error("event lost on clear");

  chk_status_clear: assert property (
    (hit(req, `OFS_STATUS) && req.wdata[`BIT_EV_HIGH]
     && !status_set[`BIT_EV_HIGH])
      |=> !status[`BIT_EV_HIGH])
    else $error("status bit not cleared by write one");

  chk_prio3_write: assert property (
    hit(req, `OFS_PRIORITY3)
      |=> peripheral_irq_priority_3 == ($past(I_WDATA) & `PRIORITY3_MASK))
    else $error("priority3 write not stored");

  chk_prio1_read_zero: assert property (
    (req.rd && req.addr == `OFS_PRIORITY1)
      |=> ((O_RDATA & ~`PRIORITY1_MASK) == `ZERO_BYTE))
    else $error("priority1 unimplemented bits read nonzero");

  chk_control_write: assert property (
    hit(req, `OFS_CONTROL)
      |=> control == ($past(I_WDATA) & `CONTROL_MASK))
    else $error("control write not stored");

  chk_rdata_idle: assert property (
    !req.rd |=> O_RDATA == `ZERO_BYTE)
    else $error("read data stands without a read");

  chk_gpe_off_high: assert property (
    (!global_priority_enable && |(I_GROUP1_FLAGS & I_GROUP1_ENABLE))
      |=> req1.high)
    else $error("request lost while global priority off");

  chk_idle_no_req: assert property (
    (I_GROUP1_FLAGS == `ZERO_BYTE) |=> !(req1.high || req1.low))
    else $error("request without a flag");

  chk_display_pass: assert property (
    (I_GROUP3_FLAGS[`BIT_DISPLAY] && display_mode_ok
     && peripheral_irq_enable_3[`BIT_DISPLAY])
      |=> (req3.high || req3.low))
    else $error("display request blocked in valid mode");

  cov_high_req: cover property (O_IRQ_HIGH);
  cov_low_req:  cover property (global_priority_enable ##1 O_IRQ_LOW);
  cov_irq_out:  cover property (O_IRQ ##[1:4] !O_IRQ);
  cov_set_clear: cover property (
    status_set[`BIT_EV_LOW] && status_clr[`BIT_EV_LOW]);
  cov_display_req: cover property (
    display_mode_ok && req3.high);

endmodule

//--- verification/test_periph_irq_ctrl.sv
// Self-checking bench for the peripheral interrupt enable/priority block.
// Assumes the design top and its package; bench drives every port itself.
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"

module test_periph_irq_ctrl
  import periph_irq_pkg::*;
;
  logic                   clk = 1'h0;
  logic                   rst_n = 1'h0;
  logic [`IRQ_ADDR_W-1:0] addr = '0;
  byte_t                  wdata = '0;
  logic                   wr = 1'h0;
  logic                   rd = 1'h0;
  byte_t                  flags1 = '0;
  byte_t                  en1 = '0;
  byte_t                  flags3 = '0;
  logic                   type_b = 1'h0;
  logic                   nonstatic = 1'h0;
  byte_t                  rdata;
  logic                   irq_high;
  logic                   irq_low;
  logic                   irq;
  byte_t                  mreg [0:6];
  byte_t                  mrd, a1, a3, e3;
  logic                   mh, ml, mhd, mld, nh, nl, rh, rl;
  int                     fails = 0;
  int                     num_checks = 0;
  byte_t msk [0:6] = '{`ENABLE3_MASK, `PRIORITY1_MASK, `PRIORITY2_MASK,
    `PRIORITY3_MASK, `CONTROL_MASK, `STATUS_MASK, `STATUS_MASK};
  byte_t rst_v [0:6] = '{`ENABLE3_RESET, `PRIORITY1_RESET, `PRIORITY2_RESET,
    `PRIORITY3_RESET, `CONTROL_RESET, `STATUS_RESET, `MASK_RESET};

  always #2.5 clk = ~clk;

  periph_irq_ctrl periph_irq_ctrl_inst (
    .I_SYS_CLK           (clk),
    .I_RESET_N           (rst_n),
    .I_ADDR              (addr),
    .I_WDATA             (wdata),
    .I_WR                (wr),
    .I_RD                (rd),
    .I_GROUP1_FLAGS      (flags1),
    .I_GROUP1_ENABLE     (en1),
    .I_GROUP3_FLAGS      (flags3),
    .I_DISPLAY_TYPE_B    (type_b),
    .I_DISPLAY_NONSTATIC (nonstatic),
    .O_RDATA             (rdata),
    .O_IRQ_HIGH          (irq_high),
    .O_IRQ_LOW           (irq_low),
    .O_IRQ               (irq)
  );

  // Reference model; blocking so the checker sees post-edge state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 7; i++) begin
        mreg[i] = rst_v[i];
      end
      {mh, ml, mhd, mld} = 4'h0;
      mrd = `ZERO_BYTE;
    end else begin
      e3 = mreg[0];
      e3[`BIT_DISPLAY] = e3[`BIT_DISPLAY] & type_b & nonstatic;
      a1 = flags1 & en1;
      a3 = flags3 & e3;
      if (mreg[4][`BIT_GPE]) begin
        nh = |((a1 & mreg[1]) | (a3 & mreg[3]));
        nl = |((a1 & ~mreg[1]) | (a3 & ~mreg[3]));
      end else begin
        nh = |(a1 | a3);
        nl = 1'h0;
      end
      rh = mh & ~mhd;
      rl = ml & ~mld;
      mhd = mh;
      mld = ml;
      mh = nh;
      ml = nl;
      mrd = (rd && addr < 7) ? mreg[addr] : `ZERO_BYTE;
      if (wr && addr == `OFS_STATUS) begin
        mreg[5] = mreg[5] & ~wdata;
      end else if (wr && addr < 7) begin
        mreg[addr] = wdata & msk[addr];
      end
      // New event beats a same-cycle clear
      mreg[5] = mreg[5] | {6'h00, rl, rh};
    end
  end

  task automatic check(input byte_t got, input byte_t exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(negedge clk) begin
    if (rst_n) begin
      check(rdata, mrd);
      check({7'h00, irq_high}, {7'h00, mh});
      check({7'h00, irq_low}, {7'h00, ml});
      check({7'h00, irq}, {7'h00, |(mreg[5] & mreg[6])});
    end
  end

  task automatic bus(input logic w, input logic r, input int a,
                     input byte_t d);
    wr <= w;
    rd <= r;
    addr <= a[`IRQ_ADDR_W-1:0];
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    wr <= 1'h0;
    rd <= 1'h0;
    repeat (n) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h53F6C441));
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (int a = 0; a < 16; a++) begin
      bus(1'h0, 1'h1, a, 8'h00);
    end
    for (int a = 0; a < 16; a++) begin
      bus(1'h1, 1'h0, a, 8'hFF);
    end
    for (int a = 0; a < 16; a++) begin
      bus(1'h0, 1'h1, a, 8'h00);
    end
    bus(1'h1, 1'h0, `OFS_ENABLE3, 8'h40);
    bus(1'h1, 1'h0, `OFS_CONTROL, 8'h01);
    flags3 <= 8'h40;
    {type_b, nonstatic} <= 2'h1;
    idle(3);
    {type_b, nonstatic} <= 2'h3;
    idle(3);
    flags3 <= 8'h00;
    en1 <= 8'hFF;
    flags1 <= 8'h40;
    bus(1'h1, 1'h0, `OFS_PRIORITY1, 8'h00);
    idle(3);
    bus(1'h1, 1'h0, `OFS_CONTROL, 8'h00);
    idle(3);
    bus(1'h1, 1'h0, `OFS_MASK, 8'h03);
    bus(1'h1, 1'h0, `OFS_STATUS, 8'h03);
    idle(2);
    // Random traffic; flags kept to implemented source bits
    for (int i = 0; i < 1500; i++) begin
      flags1 <= byte_t'($urandom) & `PRIORITY1_MASK;
      en1 <= byte_t'($urandom);
      flags3 <= byte_t'($urandom) & `ENABLE3_MASK;
      {type_b, nonstatic} <= 2'($urandom);
      bus(($urandom % 3) == 0, 1'h0, $urandom % 16, byte_t'($urandom));
      bus(1'h0, 1'h1, $urandom % 8, 8'h00);
    end
    idle(3);
    // Mid-run reset must bring every register back to its reset value
    rst_n <= 1'h0;
    idle(2);
    rst_n <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      bus(1'h0, 1'h1, a, 8'h00);
    end
    idle(3);
    complete_run();
  end

  initial begin
    repeat (8000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
